// ### rtl/twd_decoder.sv
// Function
// [RULE1] Call, file move, goto and pointer literal load are the only two-word instructions.
// [RULE2] A second word carries 1111 in its upper four bit positions.
// [RULE3] The low 12 bits of the second word form a literal operand.
// [RULE4] A second word right after its first word hands its operand to it.
// [RULE5] A 1111 word without its first word just before it is a side-effect-free no-op.
// [RULE6] An orphan second word after a skipped first word is a no-op; flow continues.
// [RULE7] Program counter counts bytes, steps by 2 per word, bit 0 reads zero.
// [RULE8] Absolute call and goto load their word address into counter bits 20:1.
`include "twd_defines.svh"

module twd_decoder (
    input  wire logic                       ref_clk,
    input  wire logic                       nrst,
    input  wire logic [`TWD_WORD_W-1:0]     fetch_word,
    input  wire logic                       fetch_valid,
    input  wire logic                       skip_next,
    input  wire logic                       branch_valid,
    input  wire logic [`TWD_PC_W-1:0]       branch_addr,
    output logic      [`TWD_PC_W-1:0]       fetch_addr,
    output logic                            exec_valid,
    output twd_pkg::twd_kind_t              exec_kind,
    output logic [`TWD_WORD_W-1:0]          exec_first,
    output logic [`TWD_LIT_W-1:0]           exec_literal,
    output logic                            exec_nop,
    output logic [`TWD_PC_W-1:0]            exec_next_pc
);
    import twd_pkg::*;

    // Jump target fills counter bits 20:1 exactly; a mismatch would drop address bits
    if (`TWD_PC_W != `TWD_ADDR_HIGH_W + `TWD_LIT_W + 1) begin : g_bad_pc
        $error("twd_decoder: counter width does not match the jump target");
    end

    // Marker nibble and literal must tile one instruction word
    if (`TWD_TOP_MSB - `TWD_TOP_LSB + 1 + `TWD_LIT_W != `TWD_WORD_W) begin : g_bad_word
        $error("twd_decoder: marker and literal fields do not fill a word");
    end

    if (`TWD_LIT_MSB + 1 != `TWD_LIT_W) begin : g_bad_lit
        $error("twd_decoder: literal field bounds disagree");
    end

    // Byte-addressed counter only works with a one-word step of two
    if (`TWD_PC_STEP != 2) begin : g_bad_step
        $error("twd_decoder: counter step is not one word");
    end

    twd_class_if cls ();

    twd_state_t                 state_q;
    twd_state_t                 state_d;
    logic [`TWD_PC_W-1:0]       pc_q;
    logic [`TWD_PC_W-1:0]       pc_d;
    logic [`TWD_PC_W-1:0]       pc_step;
    logic                       skip_q;
    logic [`TWD_WORD_W-1:0]     held_word_q;
    twd_kind_t                  held_kind_q;
    logic                       take_word;
    logic                       drop_word;
    logic                       pair_done;
    logic                       pair_broken;
    logic                       open_pair;
    logic                       lone_single;
    logic                       lone_ext;
    logic [`TWD_PC_W-2:0]       jump_word_addr;

    logic                       exec_valid_q;
    twd_kind_t                  exec_kind_q;
    logic [`TWD_WORD_W-1:0]     exec_first_q;
    logic [`TWD_LIT_W-1:0]      exec_literal_q;
    logic                       exec_nop_q;
    logic [`TWD_PC_W-1:0]       exec_next_pc_q;

    assign cls.word = fetch_word;

    twd_word_class u_class (
        .cls (cls)
    );

    // Counter steps in bytes by one word [RULE7]
    assign pc_step = pc_q + `TWD_PC_STEP;

    // Second word literal is the upper part, first word low byte the lower [RULE8]
    assign jump_word_addr = {fetch_word[`TWD_LIT_MSB:0], held_word_q[`TWD_ADDR_HIGH_W-1:0]};

    // A word skipped by the execute stage is discarded, even a first word
    assign take_word = fetch_valid && !branch_valid;
    assign drop_word = take_word && skip_q;

    always_comb begin
        pair_done   = 1'b0;
        pair_broken = 1'b0;
        open_pair   = 1'b0;
        lone_single = 1'b0;
        lone_ext    = 1'b0;
        if (take_word && !skip_q) begin
            unique case (state_q)
                TWD_ST_FIRST: begin
                    lone_ext    = cls.extension;              // [RULE5]
                    open_pair   = cls.two_word;
                    lone_single = !cls.extension && !cls.two_word;
                end
                TWD_ST_SECOND: begin
                    pair_done   = cls.extension;              // [RULE2]
                    pair_broken = !cls.extension;
                end
            endcase
        end
    end

    always_comb begin
        state_d = state_q;
        if (branch_valid) begin
            state_d = TWD_ST_FIRST;
        end else if (drop_word) begin
            // Skip lands between the words: the second then runs alone [RULE6]
            state_d = TWD_ST_FIRST;
        end else if (open_pair) begin
            state_d = TWD_ST_SECOND;
        end else if (pair_done || pair_broken) begin
            state_d = TWD_ST_FIRST;
        end
    end

    always_comb begin
        pc_d = pc_q;
        if (branch_valid) begin
            pc_d = {branch_addr[`TWD_PC_W-1:1], 1'b0};              // [RULE7]
        end else if (pair_done && (held_kind_q == TWD_GOTO || held_kind_q == TWD_CALL)) begin
            pc_d = {jump_word_addr, 1'b0};                          // [RULE8]
        end else if (take_word) begin
            pc_d = {pc_step[`TWD_PC_W-1:1], 1'b0};                  // [RULE7]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_q <= TWD_ST_FIRST;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pc_q <= `TWD_PC_RESET;
        end else begin
            pc_q <= pc_d;
        end
    end

    // A new skip request wins over the one being consumed
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            skip_q <= 1'b0;
        end else if (skip_next) begin
            skip_q <= 1'b1;
        end else if (branch_valid || drop_word) begin
            skip_q <= 1'b0;
        end
    end

    // First word is held until its partner arrives
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            held_word_q <= `TWD_NOP_WORD;
            held_kind_q <= TWD_SINGLE;
        end else if (open_pair) begin
            held_word_q <= fetch_word;
            held_kind_q <= cls.kind;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            exec_valid_q <= 1'b0;
            exec_nop_q   <= 1'b0;
        end else begin
            exec_valid_q <= lone_single || lone_ext || pair_done || pair_broken;
            // Orphan or broken pair runs with no side effects [RULE5] [RULE6]
            exec_nop_q   <= lone_ext || pair_broken;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            exec_kind_q    <= TWD_EXT_NOP;
            exec_first_q   <= `TWD_NOP_WORD;
            exec_literal_q <= '0;
        end else if (pair_done) begin
            exec_kind_q    <= held_kind_q;                          // [RULE4]
            exec_first_q   <= held_word_q;
            exec_literal_q <= fetch_word[`TWD_LIT_MSB:0];           // [RULE3] [RULE4]
        end else if (lone_single) begin
            exec_kind_q    <= TWD_SINGLE;
            exec_first_q   <= fetch_word;
            exec_literal_q <= '0;
        end else if (lone_ext || pair_broken) begin
            // Literal withheld so nothing downstream can act on it [RULE5]
            exec_kind_q    <= TWD_EXT_NOP;
            exec_first_q   <= `TWD_NOP_WORD;
            exec_literal_q <= '0;
        end
    end

    // Return point for call: address after the second word
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            exec_next_pc_q <= `TWD_PC_RESET;
        end else if (take_word && !skip_q) begin
            exec_next_pc_q <= {pc_step[`TWD_PC_W-1:1], 1'b0};
        end
    end

    assign fetch_addr   = pc_q;
    assign exec_valid   = exec_valid_q;
    assign exec_kind    = exec_kind_q;
    assign exec_first   = exec_first_q;
    assign exec_literal = exec_literal_q;
    assign exec_nop     = exec_nop_q;
    assign exec_next_pc = exec_next_pc_q;

endmodule : twd_decoder

// ### pkg/twd_defines.svh
`ifndef TWD_DEFINES_SVH
`define TWD_DEFINES_SVH

// Program memory addressing
`define TWD_PC_W          21
`define TWD_PC_STEP       21'h00_0002
`define TWD_PC_RESET      21'h00_0000

// Instruction word layout
`define TWD_WORD_W        16
`define TWD_TOP_MSB       15
`define TWD_TOP_LSB       12
`define TWD_LIT_W         12
`define TWD_LIT_MSB       11
`define TWD_EXT_PATTERN   4'hF
`define TWD_NOP_WORD      16'hF000

// First word opcode fields
`define TWD_MOVE_TOP      4'hC
`define TWD_HIGH_MSB      15
`define TWD_HIGH_LSB      8
`define TWD_GOTO_HIGH     8'hEF
`define TWD_CALL_HIGH     7'h76
`define TWD_LOAD_HIGH     8'hEE
`define TWD_LOAD_CHECK    2'h0
`define TWD_ADDR_HIGH_W   8

`endif

// ### pkg/twd_pkg.sv
package twd_pkg;

    typedef enum logic [2:0] {
        TWD_SINGLE,
        TWD_CALL,
        TWD_GOTO,
        TWD_FILE_MOVE,
        TWD_LOAD_PTR,
        TWD_EXT_NOP
    } twd_kind_t;

    typedef enum logic {
        TWD_ST_FIRST,
        TWD_ST_SECOND
    } twd_state_t;

endpackage : twd_pkg

// ### pkg/twd_class_if.sv
interface twd_class_if;
    import twd_pkg::*;

    logic [15:0] word;
    twd_kind_t   kind;
    logic        two_word;
    logic        extension;

    modport requester (
        output word,
        input  kind,
        input  two_word,
        input  extension
    );

    modport classifier (
        input  word,
        output kind,
        output two_word,
        output extension
    );

endinterface : twd_class_if

// ### rtl/twd_word_class.sv
`include "twd_defines.svh"

module twd_word_class (
    twd_class_if.classifier cls
);
    import twd_pkg::*;

    logic [`TWD_HIGH_MSB-`TWD_HIGH_LSB:0] high;

    assign high = cls.word[`TWD_HIGH_MSB:`TWD_HIGH_LSB];

    // Exactly four first-word opcodes open a pair [RULE1]
    always_comb begin
        cls.kind      = TWD_SINGLE;
        cls.two_word  = 1'b0;
        cls.extension = 1'b0;
        if (cls.word[`TWD_TOP_MSB:`TWD_TOP_LSB] == `TWD_EXT_PATTERN) begin // [RULE2]
            cls.kind      = TWD_EXT_NOP;
            cls.extension = 1'b1;
        end else if (cls.word[`TWD_TOP_MSB:`TWD_TOP_LSB] == `TWD_MOVE_TOP) begin // [RULE1]
            cls.kind     = TWD_FILE_MOVE;
            cls.two_word = 1'b1;
        end else if (high == `TWD_GOTO_HIGH) begin // [RULE1]
            cls.kind     = TWD_GOTO;
            cls.two_word = 1'b1;
        end else if (high[7:1] == `TWD_CALL_HIGH) begin // [RULE1]
            cls.kind     = TWD_CALL;
            cls.two_word = 1'b1;
        end else if (high == `TWD_LOAD_HIGH && cls.word[7:6] == `TWD_LOAD_CHECK) begin // [RULE1]
            cls.kind     = TWD_LOAD_PTR;
            cls.two_word = 1'b1;
        end
    end

endmodule : twd_word_class

// ### bench/twd_prog_mem.sv
module twd_prog_mem (
    input  wire logic        en,
    input  wire logic [20:0] addr,
    output logic             valid,
    output logic [15:0]      word
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [16];
    // Idle word inverted so stale data never passes as valid
    assign word  = en ? mem[addr[4:1]] : ~mem[addr[4:1]];
    assign valid = en;
endmodule : twd_prog_mem

// ### bench/twd_chk.sv
`include "twd_defines.svh"
module twd_chk (
    input wire logic               ref_clk,
    input wire logic               nrst,
    input wire logic [15:0]        fetch_word,
    input wire logic               fetch_valid,
    input wire logic               skip_next,
    input wire logic               branch_valid,
    input wire logic [20:0]        branch_addr,
    input wire logic [20:0]        fetch_addr,
    input wire logic               exec_valid,
    input wire twd_pkg::twd_kind_t exec_kind,
    input wire logic [15:0]        exec_first,
    input wire logic [11:0]        exec_literal,
    input wire logic               exec_nop,
    input wire logic [20:0]        exec_next_pc
);
    timeunit 1ns;
    timeprecision 1ns;
    import twd_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic jump;
    assign jump = exec_valid && (exec_kind == TWD_CALL || exec_kind == TWD_GOTO);
    pc_step_a: assert property (fetch_valid && !branch_valid |=>
        fetch_addr == $past(fetch_addr) + `TWD_PC_STEP || jump) else $error("pc step");
    pc_even_a: assert property (fetch_addr[0] == 1'b0) else $error("pc odd");
    branch_load_a: assert property (branch_valid |=>
        fetch_addr == {$past(branch_addr[20:1]), 1'b0}) else $error("branch load");
    jump_target_a: assert property (jump |->
        fetch_addr == {exec_literal, exec_first[7:0], 1'b0}) else $error("jump target");
    nop_clean_a: assert property (exec_nop |-> exec_valid && exec_first == `TWD_NOP_WORD
        && exec_literal == 12'h000) else $error("nop not clean");
    nop_kind_a: assert property (exec_valid && exec_kind == TWD_EXT_NOP |-> exec_nop)
        else $error("nop flag");
    issue_cause_a: assert property (exec_valid |-> $past(fetch_valid && !branch_valid))
        else $error("issue without fetch");
    single_word_a: assert property (exec_valid && exec_kind == TWD_SINGLE |->
        exec_literal == 12'h000 && exec_first[15:12] != 4'hF) else $error("single word");
    goto_code_a: assert property (exec_valid && exec_kind == TWD_GOTO |->
        exec_first[15:8] == 8'hEF) else $error("goto code");
    goto_c: cover property (jump);
    nop_c: cover property (exec_nop);
    branch_c: cover property (branch_valid);
endmodule : twd_chk
bind twd_decoder twd_chk twd_chk_inst (.ref_clk, .nrst, .fetch_word, .fetch_valid,
    .skip_next, .branch_valid, .branch_addr, .fetch_addr, .exec_valid, .exec_kind,
    .exec_first, .exec_literal, .exec_nop, .exec_next_pc);

// ### bench/twd_decoder_test.sv
module twd_decoder_test;
    timeunit 1ns;
    timeprecision 1ns;
    import twd_pkg::*;
    logic        ref_clk = 0, nrst = 0, fv_en = 0, skip_next = 0, branch_valid = 0;
    logic [20:0] branch_addr = 21'h00_0000;
    logic        fetch_valid, exec_valid, exec_nop;
    logic [15:0] fetch_word, exec_first;
    logic [11:0] exec_literal;
    logic [20:0] fetch_addr, exec_next_pc;
    twd_kind_t   exec_kind;
    int          err_count = 0, samples_checked = 0;

    twd_prog_mem twd_prog_mem_inst (.en(fv_en), .addr(fetch_addr), .valid(fetch_valid),
        .word(fetch_word));
    twd_decoder twd_decoder_inst (.ref_clk, .nrst, .fetch_word, .fetch_valid, .skip_next,
        .branch_valid, .branch_addr, .fetch_addr, .exec_valid, .exec_kind, .exec_first,
        .exec_literal, .exec_nop, .exec_next_pc);

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [20:0] seen, input logic [20:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One word fetched; issue expected right after the edge that takes it
    task automatic step(input logic skip, input logic issue);
        @(posedge ref_clk);
        fv_en     <= 1'b1;
        skip_next <= skip;
        @(posedge ref_clk);
        fv_en     <= 1'b0;
        skip_next <= 1'b0;
        #1;
        check(exec_valid, issue);
    endtask : step

    task automatic iss(input twd_kind_t k, input logic [15:0] f, input logic [11:0] l);
        check(exec_kind, k);
        check(exec_first, f);
        check(exec_literal, l);
        check(exec_nop, k == TWD_EXT_NOP);
    endtask : iss

    // Values that reset leaves on every output
    task automatic t_idle;
        check(exec_valid, 1'b0);
        check(exec_nop, 1'b0);
        check(exec_kind, TWD_EXT_NOP);
        check(exec_first, 16'hF000);
        check(exec_literal, 12'h000);
        check(fetch_addr, 21'h00_0000);
        check(exec_next_pc, 21'h00_0000);
    endtask : t_idle

    task automatic t_goto;
        t_idle();
        step(0, 0);
        check(fetch_addr, 21'h00_0002);
        step(0, 1);
        iss(TWD_GOTO, 16'hEF03, 12'h000);
        check(fetch_addr, 21'h00_0006);
        check(exec_next_pc, 21'h00_0004);
    endtask : t_goto

    task automatic t_skip;
        step(1, 1);
        iss(TWD_SINGLE, 16'h6600, 12'h000);
        step(0, 0);
        check(fetch_addr, 21'h00_000A);
        step(0, 1);
        iss(TWD_EXT_NOP, 16'hF000, 12'h000);
        step(0, 1);
        iss(TWD_SINGLE, 16'h2400, 12'h000);
    endtask : t_skip

    task automatic t_pairs;
        step(0, 0);
        step(0, 1);
        iss(TWD_FILE_MOVE, 16'hC123, 12'h456);
        step(0, 0);
        step(0, 1);
        iss(TWD_LOAD_PTR, 16'hEE00, 12'h0AB);
        step(0, 0);
        step(0, 1);
        iss(TWD_CALL, 16'hEC0C, 12'h000);
        check(fetch_addr, 21'h00_0018);
        check(exec_next_pc, 21'h00_001A);
        step(0, 1);
        iss(TWD_EXT_NOP, 16'hF000, 12'h000);
        step(0, 1);
        iss(TWD_SINGLE, 16'h0E55, 12'h000);
    endtask : t_pairs

    // Word offered together with a branch must be ignored
    task automatic t_branch;
        @(posedge ref_clk);
        branch_valid <= 1'b1;
        branch_addr  <= 21'h00_0003;
        fv_en        <= 1'b1;
        @(posedge ref_clk);
        branch_valid <= 1'b0;
        fv_en        <= 1'b0;
        #1;
        check(fetch_addr, 21'h00_0002);
        check(exec_valid, 1'b0);
        step(0, 1);
        iss(TWD_EXT_NOP, 16'hF000, 12'h000);
    endtask : t_branch

    // First word followed by a word without the marker
    task automatic t_broken;
        @(posedge ref_clk);
        branch_valid <= 1'b1;
        branch_addr  <= 21'h00_001C;
        @(posedge ref_clk);
        branch_valid <= 1'b0;
        step(0, 0);
        step(0, 1);
        iss(TWD_EXT_NOP, 16'hF000, 12'h000);
        check(fetch_addr, 21'h00_0020);
    endtask : t_broken

    // Reset in mid-run drops a held first word and a pending skip
    task automatic t_reset;
        step(1, 0);
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        #1;
        t_idle();
        step(0, 0);
        step(0, 1);
        iss(TWD_GOTO, 16'hEF03, 12'h000);
        check(fetch_addr, 21'h00_0006);
    endtask : t_reset

    task automatic summarize;
        $display("Comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    initial begin
        #20_000;
        err_count++;
        summarize();
    end

    initial begin
        twd_prog_mem_inst.mem = '{16'hEF03, 16'hF000, 16'h0000, 16'h6600, 16'hC123, 16'hF456,
            16'h2400, 16'hC123, 16'hF456, 16'hEE00, 16'hF0AB, 16'hEC0C, 16'hF000, 16'h0E55,
            16'hEF05, 16'h0000};
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        #1;
        t_goto();
        t_skip();
        t_pairs();
        t_branch();
        t_broken();
        t_reset();
        summarize();
    end
endmodule : twd_decoder_test
